// ==== lcd_host_model.sv ====
`timescale 1ns/100ps
`include "lcd_port_params.svh"
module lcd_host_model (
    // Clock and device answer
    input  wire logic                 mclk,
    input  wire lcd_port_pkg::byte_t  host_data_out,
    input  wire logic                 host_data_oe_n,
    // Host pins
    output logic                      host_enable,
    output logic                      host_read_write,
    output logic                      select_line_low,
    output logic                      select_line_high,
    output lcd_port_pkg::byte_t       host_data_in
);
    import lcd_port_pkg::*;
    initial begin
        {host_enable, host_read_write} = 2'b01;
        {select_line_high, select_line_low} = `SEL_NONE;
        host_data_in = 8'h00;
    end
    // Released data lines flip so a stale byte never looks valid
    task automatic acc(input logic rw, input sel_t sel, input byte_t wd, input int hi,
                       output byte_t rd, output logic oe);
        @(negedge mclk);
        host_read_write <= rw;
        {select_line_high, select_line_low} <= sel;
        host_data_in <= rw ? ~host_data_in : wd;
        host_enable <= 1'b1;
        repeat (hi) @(negedge mclk);
        // A floating bus reads back inverted, never as a valid byte
        rd = host_data_oe_n ? ~host_data_out : host_data_out;
        oe = host_data_oe_n;
        host_enable <= 1'b0;
        repeat (3) @(negedge mclk);
        host_data_in <= ~host_data_in;
    endtask : acc
endmodule : lcd_host_model

// ==== lcd_host_register_port.sv ====
`timescale 1ns/100ps
`include "lcd_port_params.svh"

module lcd_host_register_port (
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  rst,
    // Host parallel bus pins
    input  wire logic                  host_enable,
    input  wire logic                  host_read_write,
    input  wire logic                  select_line_low,
    input  wire logic                  select_line_high,
    input  wire lcd_port_pkg::byte_t   host_data_in,
    output lcd_port_pkg::byte_t        host_data_out,
    output logic                       host_data_oe_n,
    // Device side
    output logic [`CONTRAST_MSB:0]     contrast_code,
    output logic                       busy_indicator
);
    import lcd_port_pkg::*;

    // Pin synchronisers; stage 1 is read only by stage 2
    logic   e_s1;
    logic   e_s2;
    logic   e_s3;
    logic   rw_s1;
    logic   rw_s2;
    sel_t   sel_s1;
    sel_t   sel_s2;
    byte_t  dat_s1;
    byte_t  dat_s2;

    state_e                state;
    state_e                next_state;
    region_e               region;
    logic [`PTR_MSB:0]     ptr;
    logic [`PTR_MSB:0]     next_ptr;
    logic                  dir_up;
    byte_t                 data_transfer_latch;
    byte_t                 store_byte;
    logic [7:0]            settle_cnt;

    logic  strobe;
    logic  idle;
    logic  wr_ins;
    logic  wr_ext;
    logic  wr_dat;
    logic  rd_dat;
    logic  rd_drive;
    logic  ins_addr;
    logic  ext_addr;
    logic  settle_done;
    logic  accept;
    logic  sel_data;
    logic  sel_instr;
    logic  sel_ext;
    logic  sel_none;
    byte_t status_byte;
    byte_t rd_byte;

    ram_if ram ();

    lcd_ram u_ram (
        .mclk (mclk),
        .ram  (ram)
    );

    // Enable takes a third stage so its falling edge can be seen
    always_ff @(posedge mclk) begin
        if (rst) begin
            e_s1 <= 1'b0;
            e_s2 <= 1'b0;
            e_s3 <= 1'b0;
        end else begin
            e_s1 <= host_enable;
            e_s2 <= e_s1;
            e_s3 <= e_s2;
        end
    end

    // Direction comes up as read, the pin's idle level
    always_ff @(posedge mclk) begin
        if (rst) begin
            rw_s1 <= 1'b1;
            rw_s2 <= 1'b1;
        end else begin
            rw_s1 <= host_read_write;
            rw_s2 <= rw_s1;
        end
    end

    // Select lines come up unselected
    always_ff @(posedge mclk) begin
        if (rst) begin
            sel_s1 <= `SEL_NONE;
            sel_s2 <= `SEL_NONE;
        end else begin
            sel_s1 <= {select_line_high, select_line_low};
            sel_s2 <= sel_s1;
        end
    end

    // Bytes need no extra stage: the host holds them around the strobe
    always_ff @(posedge mclk) begin
        if (rst) begin
            dat_s1 <= `BYTE_RESET;
            dat_s2 <= `BYTE_RESET;
        end else begin
            dat_s1 <= host_data_in;
            dat_s2 <= dat_s1;
        end
    end

    // Accesses take effect on the falling edge of enable
    assign strobe = e_s3 & ~e_s2;
    assign idle   = (state == ST_IDLE);

    // Selection decode from the synchronised pins
    assign accept    = strobe & idle;
    assign sel_data  = (sel_s2 == `SEL_DATA);
    assign sel_instr = (sel_s2 == `SEL_INSTR);
    assign sel_ext   = (sel_s2 == `SEL_EXT);
    assign sel_none  = (sel_s2 == `SEL_NONE);

    // Nothing is accepted while busy, so a mistimed host loses its access
    assign wr_ins = accept & ~rw_s2 & sel_instr;
    assign wr_ext = accept & ~rw_s2 & sel_ext;
    assign wr_dat = accept & ~rw_s2 & sel_data;
    assign rd_dat = accept & rw_s2 & sel_data;

    // Address codes, which trigger a prefetch
    assign ins_addr = dat_s2[`INS_DISP_BIT] | dat_s2[`INS_GLYPH_BIT];
    assign ext_addr = dat_s2[`EXT_ICON_BIT];

    // Last settle cycle hands back to idle
    assign settle_done = (settle_cnt >= 8'(`BUSY_CYCLES - 1));

    // Pointer wraps at both ends of its range
    always_comb begin
        next_ptr = dir_up ? 7'(ptr + `PTR_STEP) : 7'(ptr - `PTR_STEP);
    end

    // One transfer at a time; every path ends in the settle wait
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (wr_dat) begin
                    next_state = ST_STORE;
                end else if (rd_dat) begin
                    next_state = ST_FETCH;
                end else if ((wr_ins & ins_addr) | (wr_ext & ext_addr)) begin
                    next_state = ST_FETCH;
                end else if (wr_ins | wr_ext) begin
                    next_state = ST_SETTLE;
                end
            end
            ST_STORE: begin
                next_state = ST_FETCH;
            end
            ST_FETCH: begin
                next_state = ST_LOAD;
            end
            ST_LOAD: begin
                next_state = ST_SETTLE;
            end
            ST_SETTLE: begin
                if (settle_done) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Busy follows the next state, so it rises with the accepting edge
    always_ff @(posedge mclk) begin
        if (rst) begin
            busy_indicator <= 1'b0;
        end else begin
            busy_indicator <= (next_state != ST_IDLE);
        end
    end

    // Counts the fixed internal operation time
    always_ff @(posedge mclk) begin
        if (rst) begin
            settle_cnt <= `CNT_RESET;
        end else if (state == ST_SETTLE) begin
            settle_cnt <= 8'(settle_cnt + `CNT_STEP);
        end else begin
            settle_cnt <= `CNT_RESET;
        end
    end

    // Pointer and RAM selection
    always_ff @(posedge mclk) begin
        if (rst) begin
            region <= REG_DISPLAY;
        end else if (wr_ins & dat_s2[`INS_DISP_BIT]) begin
            region <= REG_DISPLAY;
        end else if (wr_ins & dat_s2[`INS_GLYPH_BIT]) begin
            region <= REG_GLYPH;
        end else if (wr_ext & ext_addr) begin
            region <= REG_ICON;
        end
    end

    // Glyph addresses are six bits wide, top bit cleared
    always_ff @(posedge mclk) begin
        if (rst) begin
            ptr <= `PTR_RESET;
        end else if (wr_ins & dat_s2[`INS_DISP_BIT]) begin
            ptr <= dat_s2[`PTR_MSB:0];
        end else if (wr_ins & dat_s2[`INS_GLYPH_BIT]) begin
            ptr <= {1'b0, dat_s2[`GLYPH_MSB:0]};
        end else if (wr_ext & ext_addr) begin
            ptr <= dat_s2[`PTR_MSB:0];
        end else if (rd_dat | (state == ST_STORE)) begin
            ptr <= next_ptr;
        end
    end

    // Step direction, from the entry-mode instruction
    always_ff @(posedge mclk) begin
        if (rst) begin
            dir_up <= `DIR_RESET;
        end else if (wr_ins & ~ins_addr & dat_s2[`INS_MODE_BIT]) begin
            dir_up <= dat_s2[`INS_DIR_BIT];
        end
    end

    // Contrast applies at once; there is no shadow copy
    always_ff @(posedge mclk) begin
        if (rst) begin
            contrast_code <= `CONTRAST_RESET;
        end else if (wr_ext & ~ext_addr) begin
            contrast_code <= dat_s2[`CONTRAST_MSB:0];
        end
    end

    // Written byte kept until the store cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            store_byte <= `BYTE_RESET;
        end else if (wr_dat) begin
            store_byte <= dat_s2;
        end
    end

    // Latch shows the written byte at once, then the prefetched next one
    always_ff @(posedge mclk) begin
        if (rst) begin
            data_transfer_latch <= `BYTE_RESET;
        end else if (wr_dat) begin
            data_transfer_latch <= dat_s2;
        end else if (state == ST_LOAD) begin
            data_transfer_latch <= ram.rdata;
        end
    end

    // One shared RAM, region bits above the pointer
    assign ram.we    = (state == ST_STORE);
    assign ram.addr  = {region, ptr};
    assign ram.wdata = store_byte;

    // Drive the bus while a selected read holds enable high
    assign rd_drive = e_s2 & rw_s2 & ~sel_none;

    // Pointer moves during work, so zeros are shown instead
    assign status_byte = {busy_indicator, busy_indicator ? `PTR_RESET : ptr};

    // Read mux; an unselected read gives zero
    always_comb begin
        rd_byte = `BYTE_RESET;
        case (sel_s2)
            `SEL_DATA: begin
                rd_byte = data_transfer_latch;
            end
            `SEL_INSTR: begin
                rd_byte = status_byte;
            end
            `SEL_EXT: begin
                rd_byte = {3'b000, contrast_code};
            end
            default: begin
                rd_byte = `BYTE_RESET;
            end
        endcase
    end

    // Bus floats unless a selected read is in progress
    always_ff @(posedge mclk) begin
        if (rst) begin
            host_data_oe_n <= 1'b1;
        end else begin
            host_data_oe_n <= ~rd_drive;
        end
    end

    // Data stays live while enable is high, so the busy bit updates
    always_ff @(posedge mclk) begin
        if (rst) begin
            host_data_out <= `BYTE_RESET;
        end else if (rd_drive) begin
            host_data_out <= rd_byte;
        end else begin
            host_data_out <= `BYTE_RESET;
        end
    end

endmodule : lcd_host_register_port

// ==== lcd_host_register_port_tb_top.sv ====
`timescale 1ns/100ps
`include "lcd_port_params.svh"
module lcd_host_register_port_tb_top;
    import lcd_port_pkg::*;
    logic                   mclk;
    logic                   rst;
    logic                   host_enable;
    logic                   host_read_write;
    logic                   select_line_low;
    logic                   select_line_high;
    byte_t                  host_data_in;
    byte_t                  host_data_out;
    logic                   host_data_oe_n;
    logic [`CONTRAST_MSB:0] contrast_code;
    logic                   busy_indicator;
    byte_t                  rd;
    logic                   oe;
    int                     miscompares = 0;
    int                     n_checks = 0;
    lcd_host_register_port dut (.mclk(mclk), .rst(rst), .host_enable(host_enable),
        .host_read_write(host_read_write), .select_line_low(select_line_low),
        .select_line_high(select_line_high), .host_data_in(host_data_in),
        .host_data_out(host_data_out), .host_data_oe_n(host_data_oe_n),
        .contrast_code(contrast_code), .busy_indicator(busy_indicator));
    lcd_host_model host (.mclk(mclk), .host_data_out(host_data_out),
        .host_data_oe_n(host_data_oe_n), .host_enable(host_enable),
        .host_read_write(host_read_write), .select_line_low(select_line_low),
        .select_line_high(select_line_high), .host_data_in(host_data_in));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic results;
        if (miscompares == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results
    task automatic ck(input string what, input byte_t exp, input byte_t got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : ck
    // Polls status; leaves the last status byte in rd
    task automatic idle;
        for (int i = 0; i < 20; i++) begin
            host.acc(1'b1, `SEL_INSTR, 8'h00, 5, rd, oe);
            if (rd[`BUSY_BIT] === 1'b0)
                return;
        end
        miscompares++;
        results();
    endtask : idle
    task automatic wr(input sel_t sel, input byte_t wd);
        host.acc(1'b0, sel, wd, 5, rd, oe);
        idle();
    endtask : wr
    task automatic rdd(input byte_t exp);
        host.acc(1'b1, `SEL_DATA, 8'h00, 5, rd, oe);
        ck("data", exp, rd);
        idle();
    endtask : rdd
    task automatic sc_reset;
        ck("oe_n", 8'h01, {7'h00, host_data_oe_n});
        idle();
        ck("status", 8'h00, rd);
    endtask : sc_reset
    task automatic sc_contrast;
        wr(`SEL_EXT, 8'h15);
        ck("contrast", 8'h15, {3'h0, contrast_code});
        host.acc(1'b1, `SEL_EXT, 8'h00, 5, rd, oe);
        ck("ext", 8'h15, rd);
    endtask : sc_contrast
    task automatic sc_stream;
        wr(`SEL_INSTR, 8'h85);
        ck("status", 8'h05, rd);
        wr(`SEL_DATA, 8'hA1);
        wr(`SEL_DATA, 8'hB2);
        ck("ptr", 8'h07, rd);
        wr(`SEL_INSTR, 8'h85);
        rdd(8'hA1);
        rdd(8'hB2);
        ck("ptr", 8'h07, rd);
        wr(`SEL_INSTR, 8'h04);
        wr(`SEL_INSTR, 8'h83);
        wr(`SEL_DATA, 8'hC3);
        ck("ptr_down", 8'h02, rd);
        wr(`SEL_INSTR, 8'h06);
    endtask : sc_stream
    // Same pointer in all three RAM regions must stay distinct
    task automatic sc_regions;
        sel_t  sl[3] = '{`SEL_INSTR, `SEL_INSTR, `SEL_EXT};
        byte_t cm[3] = '{8'h82, 8'h42, 8'h82};
        for (int i = 0; i < 3; i++) begin
            wr(sl[i], cm[i]);
            wr(`SEL_DATA, 8'h30 | i[7:0]);
        end
        for (int i = 0; i < 3; i++) begin
            wr(sl[i], cm[i]);
            rdd(8'h30 | i[7:0]);
        end
        ck("contrast", 8'h15, {3'h0, contrast_code});
    endtask : sc_regions
    task automatic sc_none;
        host.acc(1'b0, `SEL_NONE, 8'h1F, 5, rd, oe);
        repeat (3) @(negedge mclk);
        ck("busy", 8'h00, {7'h00, busy_indicator});
        host.acc(1'b1, `SEL_NONE, 8'h00, 5, rd, oe);
        ck("oe_none", 8'h01, {7'h00, oe});
        ck("contrast", 8'h15, {3'h0, contrast_code});
    endtask : sc_none
    task automatic sc_busy;
        wr(`SEL_INSTR, 8'h80);
        host.acc(1'b0, `SEL_DATA, 8'hD4, 5, rd, oe);
        host.acc(1'b1, `SEL_INSTR, 8'h00, 4, rd, oe);
        ck("busy_status", 8'h80, rd);
        idle();
        host.acc(1'b0, `SEL_DATA, 8'hE5, 5, rd, oe);
        host.acc(1'b0, `SEL_EXT, 8'h0A, 3, rd, oe);
        idle();
        ck("contrast", 8'h15, {3'h0, contrast_code});
        ck("ptr", 8'h02, rd);
    endtask : sc_busy
    initial begin
        repeat (30000) @(posedge mclk);
        miscompares++;
        results();
    end
    initial begin
        rst = 1'b1;
        repeat (16) @(negedge mclk);
        rst = 1'b0;
        sc_reset();
        sc_contrast();
        sc_stream();
        sc_regions();
        sc_none();
        sc_busy();
        results();
    end
endmodule : lcd_host_register_port_tb_top

// ==== lcd_port_checker.sv ====
`timescale 1ns/100ps
`include "lcd_port_params.svh"
module lcd_port_checker (
    // Clock and reset
    input wire logic                   mclk,
    input wire logic                   rst,
    // Host pins
    input wire logic                   host_enable,
    input wire logic                   host_read_write,
    input wire logic                   select_line_low,
    input wire logic                   select_line_high,
    input wire lcd_port_pkg::byte_t    host_data_in,
    input wire lcd_port_pkg::byte_t    host_data_out,
    input wire logic                   host_data_oe_n,
    // Device side
    input wire logic [`CONTRAST_MSB:0] contrast_code,
    input wire logic                   busy_indicator
);
    import lcd_port_pkg::*;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);
    logic st_rd;
    logic ex_rd;
    assign st_rd = host_enable && host_read_write && select_line_high && !select_line_low;
    assign ex_rd = host_enable && host_read_write && !select_line_high && !select_line_low;
    a_busy_min_time: assert property ($rose(busy_indicator) |-> busy_indicator[*4])
        else $error("busy shorter than settle time");
    a_busy_max_time: assert property ($rose(busy_indicator) |-> ##[1:7] !busy_indicator)
        else $error("busy held too long");
    a_bus_release: assert property ($fell(host_enable) |-> ##4 host_data_oe_n)
        else $error("bus still driven after strobe");
    a_write_float: assert property ((host_enable && !host_read_write)[*4] |-> host_data_oe_n)
        else $error("bus driven during write");
    a_none_float: assert property (
        (host_enable && select_line_low && !select_line_high)[*4] |-> host_data_oe_n)
        else $error("bus driven while unselected");
    a_status_busy: assert property (
        st_rd[*5] ##0 (!host_data_oe_n && $stable(busy_indicator))
        |-> host_data_out[`BUSY_BIT] == busy_indicator)
        else $error("status bit 7 differs from busy");
    a_busy_ptr: assert property (
        st_rd[*5] ##0 (!host_data_oe_n && host_data_out[`BUSY_BIT])
        |-> host_data_out[`PTR_MSB:0] == 7'h00)
        else $error("pointer shown while busy");
    a_ext_read: assert property (
        ex_rd[*5] ##0 !host_data_oe_n
        |-> host_data_out == {3'h0, contrast_code})
        else $error("extension read differs from contrast");
    a_contrast_busy: assert property ($changed(contrast_code) |-> ##[0:1] busy_indicator)
        else $error("contrast changed without busy");
endmodule : lcd_port_checker
bind lcd_host_register_port lcd_port_checker chk_i (.mclk(mclk), .rst(rst),
    .host_enable(host_enable), .host_read_write(host_read_write),
    .select_line_low(select_line_low), .select_line_high(select_line_high),
    .host_data_in(host_data_in), .host_data_out(host_data_out),
    .host_data_oe_n(host_data_oe_n), .contrast_code(contrast_code),
    .busy_indicator(busy_indicator));

// ==== lcd_port_params.svh ====
`ifndef LCD_PORT_PARAMS_SVH
`define LCD_PORT_PARAMS_SVH

// Register selection, written as {select_line_high, select_line_low}
`define SEL_DATA        2'b11
`define SEL_INSTR       2'b10
`define SEL_EXT         2'b00
`define SEL_NONE        2'b01

// Host data bus fields
`define BUSY_BIT        7
`define PTR_MSB         6
`define INS_DISP_BIT    7
`define INS_GLYPH_BIT   6
`define INS_MODE_BIT    2
`define INS_DIR_BIT     1
`define GLYPH_MSB       5
`define EXT_ICON_BIT    7
`define CONTRAST_MSB    4

// Reset and step values
`define PTR_RESET       7'h00
`define PTR_STEP        7'h01
`define CONTRAST_RESET  5'h00
`define DIR_RESET       1'b1
`define BYTE_RESET      8'h00
`define CNT_RESET       8'h00
`define CNT_STEP        8'h01

// Internal operation time after a transfer or instruction
`define CLK_PERIOD_NS   10
`define BUSY_TIME_NS    40
`define BUSY_CYCLES     ((`BUSY_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Unified RAM: {region, pointer}
`define MEM_AW          9
`define MEM_DEPTH       512

`endif

// ==== lcd_port_pkg.sv ====
package lcd_port_pkg;

    typedef logic [7:0] byte_t;
    typedef logic [1:0] sel_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_STORE  = 3'b001,
        ST_FETCH  = 3'b010,
        ST_LOAD   = 3'b011,
        ST_SETTLE = 3'b100
    } state_e;

    typedef enum logic [1:0] {
        REG_DISPLAY = 2'b00,
        REG_GLYPH   = 2'b01,
        REG_ICON    = 2'b10
    } region_e;

endpackage : lcd_port_pkg

// ==== lcd_ram.sv ====
`timescale 1ns/100ps
`include "lcd_port_params.svh"

module lcd_ram (
    // Clock
    input  wire logic   mclk,
    // Port
    ram_if.store        ram
);
    import lcd_port_pkg::*;

    byte_t mem [0:`MEM_DEPTH-1];

    // Read data always registered; contents are not reset
    always_ff @(posedge mclk) begin
        if (ram.we) begin
            mem[ram.addr] <= ram.wdata;
        end
        ram.rdata <= mem[ram.addr];
    end

endmodule : lcd_ram

// ==== ram_if.sv ====
`timescale 1ns/100ps
`include "lcd_port_params.svh"

interface ram_if;
    import lcd_port_pkg::*;

    logic                we;
    logic [`MEM_AW-1:0]  addr;
    byte_t               wdata;
    byte_t               rdata;

    modport ctrl  (output we, output addr, output wdata, input rdata);
    modport store (input we, input addr, input wdata, output rdata);
endinterface : ram_if
